// file: rtl/steer_pkg.sv
// Package of register map, field layout and types for the DMA/interrupt steering block
package steer_pkg;
    localparam int          NUM_DMA_PAIRS   = 2;
    localparam int          NUM_IRQ_LINES   = 2;
    // Register byte addresses
    localparam logic [11:0] DMA_ROUTE0_ADDR = 12'h000;
    localparam logic [11:0] DMA_ROUTE1_ADDR = 12'h004;
    localparam logic [11:0] IRQ_ROUTE0_ADDR = 12'h008;
    localparam logic [11:0] IRQ_ROUTE1_ADDR = 12'h00C;
    localparam logic [11:0] STATUS_ADDR     = 12'h010;
    // DMA route register fields
    localparam int          DMA_CH_LSB      = 0;
    localparam int          DMA_EN_BIT      = 3;
    localparam logic [3:0]  DMA_ROUTE_RESET = 4'h4;
    // Interrupt route register fields
    localparam int          IRQ_NUM_LSB     = 0;
    localparam int          IRQ_SHARE_BIT   = 5;
    localparam int          IRQ_ROUTE_BIT   = 7;
    localparam int          IRQ_TMR_OE_BIT  = 6;
    localparam logic [7:0]  IRQ_ROUTE_RESET = 8'h00;
    // Legal targets
    localparam logic [7:0]  DMA_CH_LEGAL    = 8'hEF;
    localparam logic [15:0] IRQ_LEGAL       = 16'hDEF8;

    typedef struct packed {
        logic       enable;
        logic [2:0] channel;
    } dma_route_t;

    typedef struct packed {
        logic       routed;
        logic       timer_oe;
        logic       share;
        logic [4:0] number;
    } irq_route_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
    } ahb_req_t;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b01,
        BUS_WRITE = 2'b10
    } bus_state_t;
endpackage

// file: rtl/board_steer.sv
// Motherboard DMA and interrupt steering with an AHB-Lite register slave
`timescale 1ns/1ps
module board_steer
    import steer_pkg::*;
#(
    parameter int DMA_PAIRS = NUM_DMA_PAIRS,
    parameter int IRQ_LINES = NUM_IRQ_LINES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic [DMA_PAIRS-1:0] board_dma_request,
    output logic      [DMA_PAIRS-1:0] board_dma_acknowledge_n,
    input  wire logic [7:0]           isa_dack,
    output logic      [7:0]           isa_dreq,
    input  wire logic [IRQ_LINES-1:0] board_interrupt_line_i,
    output logic      [IRQ_LINES-1:0] board_interrupt_line_o,
    output logic      [IRQ_LINES-1:0] board_interrupt_line_oe,
    input  wire logic                 timer_irq,
    input  wire logic [15:0]          isa_irq,
    output logic      [15:0]          ctrl_irq
);

    // The register map holds two route words of each kind
    if (DMA_PAIRS < 1 || DMA_PAIRS > NUM_DMA_PAIRS || IRQ_LINES < 1 || IRQ_LINES > NUM_IRQ_LINES) begin : gen_bad_count
        $error("board_steer: pair or line count out of range");
    end

    function automatic logic addr_hit(input logic [31:0] a, input logic [11:0] base, input int idx);
        addr_hit = (a[11:0] == base + 12'(4 * idx));
    endfunction

    dma_route_t dma_route_q [DMA_PAIRS];
    dma_route_t dma_route_d [DMA_PAIRS];
    irq_route_t irq_route_q [IRQ_LINES];
    irq_route_t irq_route_d [IRQ_LINES];
    bus_state_t state_q, state_d;
    logic [31:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0]  dreq_q, dreq_d;
    logic [DMA_PAIRS-1:0] dak_n_q, dak_n_d;
    logic [IRQ_LINES-1:0] mo_q, mo_d, moe_q, moe_d;
    logic [15:0] irq_q, irq_d;
    ahb_req_t req;

    always_comb begin
        req.hsel   = hsel;
        req.haddr  = haddr;
        req.htrans = htrans;
        req.hwrite = hwrite;
        req.hsize  = hsize;
        req.hready = hready;
    end

    function automatic logic [31:0] read_word(input logic [31:0] a, input dma_route_t d[DMA_PAIRS],
                                              input irq_route_t r[IRQ_LINES], input logic [7:0] dq,
                                              input logic [15:0] iq);
        read_word = 32'h0000_0000;
        for (int i = 0; i < DMA_PAIRS; i++) begin
            if (addr_hit(a, DMA_ROUTE0_ADDR, i)) begin
                read_word = {28'h000_0000, d[i]};
            end
        end
        for (int i = 0; i < IRQ_LINES; i++) begin
            if (addr_hit(a, IRQ_ROUTE0_ADDR, i)) begin
                read_word = {24'h00_0000, r[i]};
            end
        end
        if (addr_hit(a, STATUS_ADDR, 0)) begin
            read_word = {iq, dq, 8'h00};
        end
    endfunction

    // Bus slave: zero wait states, always OKAY, unmapped reads zero
    always_comb begin
        state_d = state_q;
        addr_d  = addr_q;
        rdata_d = rdata_q;
        for (int i = 0; i < DMA_PAIRS; i++) begin
            dma_route_d[i] = dma_route_q[i];
        end
        for (int i = 0; i < IRQ_LINES; i++) begin
            irq_route_d[i] = irq_route_q[i];
        end
        case (state_q)
            BUS_WRITE: begin
                for (int i = 0; i < DMA_PAIRS; i++) begin
                    if (addr_hit(addr_q, DMA_ROUTE0_ADDR, i)) begin
                        dma_route_d[i] = dma_route_t'(hwdata[3:0]);
                    end
                end
                for (int i = 0; i < IRQ_LINES; i++) begin
                    if (addr_hit(addr_q, IRQ_ROUTE0_ADDR, i)) begin
                        irq_route_d[i] = irq_route_t'(hwdata[7:0]);
                    end
                end
            end
            BUS_IDLE: begin
            end
            default: begin
                state_d = BUS_IDLE;
            end
        endcase
        state_d = BUS_IDLE;
        if (req.hsel && req.hready && req.htrans[1]) begin
            addr_d = req.haddr;
            if (req.hwrite) begin
                state_d = BUS_WRITE;
            end else begin
                // A write landing in this cycle is already visible to a back-to-back read
                rdata_d = read_word(req.haddr, dma_route_d, irq_route_d, dreq_q, irq_q);
            end
        end
    end

    // Steering datapath
    always_comb begin
        dreq_d  = 8'h00;
        dak_n_d = '1;
        irq_d   = isa_irq;
        mo_d    = '0;
        moe_d   = '0;
        for (int i = 0; i < DMA_PAIRS; i++) begin
            if (dma_route_q[i].enable && DMA_CH_LEGAL[dma_route_q[i].channel]) begin
                dreq_d[dma_route_q[i].channel] = dreq_d[dma_route_q[i].channel] | board_dma_request[i];
                dak_n_d[i] = ~isa_dack[dma_route_q[i].channel];
            end
        end
        for (int i = 0; i < IRQ_LINES; i++) begin
            if (i == 0 && irq_route_q[i].timer_oe) begin
                mo_d[i]  = timer_irq;
                moe_d[i] = 1'b1;
            end else if (irq_route_q[i].routed && IRQ_LEGAL[irq_route_q[i].number[3:0]]
                         && !irq_route_q[i].number[4]) begin
                if (!irq_route_q[i].share) begin
                    irq_d[irq_route_q[i].number[3:0]] = 1'b0;
                end
            end
        end
        for (int i = 0; i < IRQ_LINES; i++) begin
            if (!(i == 0 && irq_route_q[i].timer_oe) && irq_route_q[i].routed
                && IRQ_LEGAL[irq_route_q[i].number[3:0]] && !irq_route_q[i].number[4]) begin
                // Shared inputs OR together; level-high sources assumed
                irq_d[irq_route_q[i].number[3:0]] = irq_d[irq_route_q[i].number[3:0]]
                                                    | board_interrupt_line_i[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= BUS_IDLE;
            addr_q  <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            dreq_q  <= 8'h00;
            dak_n_q <= '1;
            irq_q   <= 16'h0000;
            mo_q    <= '0;
            moe_q   <= '0;
            for (int i = 0; i < DMA_PAIRS; i++) begin
                dma_route_q[i] <= dma_route_t'(DMA_ROUTE_RESET);
            end
            for (int i = 0; i < IRQ_LINES; i++) begin
                irq_route_q[i] <= irq_route_t'(IRQ_ROUTE_RESET);
            end
        end else begin
            state_q <= state_d;
            addr_q  <= addr_d;
            rdata_q <= rdata_d;
            dreq_q  <= dreq_d;
            dak_n_q <= dak_n_d;
            irq_q   <= irq_d;
            mo_q    <= mo_d;
            moe_q   <= moe_d;
            for (int i = 0; i < DMA_PAIRS; i++) begin
                dma_route_q[i] <= dma_route_d[i];
            end
            for (int i = 0; i < IRQ_LINES; i++) begin
                irq_route_q[i] <= irq_route_d[i];
            end
        end
    end

    assign hrdata                  = rdata_q;
    assign hreadyout               = 1'b1;
    assign hresp                   = 1'b0;
    assign isa_dreq                = dreq_q;
    assign board_dma_acknowledge_n = dak_n_q;
    assign ctrl_irq                = irq_q;
    assign board_interrupt_line_o  = mo_q;
    assign board_interrupt_line_oe = moe_q;

    // Targets claimed by pairs and lines other than the first, read by the assertions
    logic [7:0]  dma_hit;
    logic [15:0] other_hit;

    always_comb begin
        dma_hit   = 8'h00;
        other_hit = 16'h0000;
        for (int i = 1; i < DMA_PAIRS; i++) begin
            if (dma_route_q[i].enable) begin
                dma_hit[dma_route_q[i].channel] = 1'b1;
            end
        end
        for (int i = 1; i < IRQ_LINES; i++) begin
            if (irq_route_q[i].routed && !irq_route_q[i].number[4]) begin
                other_hit[irq_route_q[i].number[3:0]] = 1'b1;
            end
        end
    end

    // Assertions
    unrouted_dak_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        !$past(dma_route_q[0].enable) |-> board_dma_acknowledge_n[0])
        else $error("acknowledge asserted on unrouted pair");
    dreq_follow_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        (dma_route_q[0].enable && dma_route_q[0].channel == 3'd1 && board_dma_request[0])
        |=> isa_dreq[1])
        else $error("routed request not driven to channel");
    dak_follow_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        (dma_route_q[0].enable && dma_route_q[0].channel == 3'd6 && isa_dack[6])
        |=> !board_dma_acknowledge_n[0])
        else $error("acknowledge not followed");
    no_chan4_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        !isa_dreq[4])
        else $error("channel four driven");
    timer_out_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        irq_route_q[0].timer_oe |=> (board_interrupt_line_oe[0] && board_interrupt_line_o[0] == $past(timer_irq)))
        else $error("timer output not driven");
    mask_isa_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!irq_route_q[0].timer_oe && irq_route_q[0].routed && irq_route_q[0].number == 5'd5
         && !irq_route_q[0].share && !board_interrupt_line_i[0]
         && !other_hit[5]) |=> !ctrl_irq[5])
        else $error("ISA interrupt not masked");
    share_isa_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!irq_route_q[0].timer_oe && irq_route_q[0].routed && irq_route_q[0].number == 5'd9
         && irq_route_q[0].share && isa_irq[9] && !other_hit[9]) |=> ctrl_irq[9])
        else $error("shared ISA interrupt lost");
    route_irq_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!irq_route_q[0].timer_oe && irq_route_q[0].routed && irq_route_q[0].number == 5'd10
         && board_interrupt_line_i[0]) |=> ctrl_irq[10])
        else $error("board interrupt not routed");
    reg_write_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        (state_q == BUS_WRITE && addr_q[11:0] == IRQ_ROUTE0_ADDR)
        |=> irq_route_q[0] == irq_route_t'($past(hwdata[7:0])))
        else $error("route register not written");

    // Address phase of a single transfer to one register
    sequence write_addr_s(logic [11:0] a);
        hsel && hready && htrans[1] && hwrite && haddr[11:0] == a;
    endsequence

    sequence read_addr_s(logic [11:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr[11:0] == a;
    endsequence

    dma_write_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        write_addr_s(DMA_ROUTE0_ADDR) ##1 hready |=> dma_route_q[0] == dma_route_t'($past(hwdata[3:0])))
        else $error("pair route register not written");
    dma_read_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        read_addr_s(DMA_ROUTE0_ADDR) |=> hrdata == {28'h000_0000, dma_route_q[0]})
        else $error("pair route read back wrong");
    irq_read_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        read_addr_s(IRQ_ROUTE0_ADDR) |=> hrdata == {24'h00_0000, irq_route_q[0]})
        else $error("line route read back wrong");
    status_read_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        read_addr_s(STATUS_ADDR) |=> hrdata == {$past(ctrl_irq), $past(isa_dreq), 8'h00})
        else $error("status read back wrong");
    dak_chan4_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        dma_route_q[0].channel == 3'd4 |=> board_dma_acknowledge_n[0])
        else $error("acknowledge on channel four");
    dreq_unrouted_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!dma_route_q[0].enable && dma_route_q[0].channel == 3'd2 && board_dma_request[0] && !dma_hit[2])
        |=> !isa_dreq[2])
        else $error("unrouted request reached channel");
    irq_unrouted_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!irq_route_q[0].routed && irq_route_q[0].number == 5'd6 && board_interrupt_line_i[0]
         && !isa_irq[6] && !other_hit[6]) |=> !ctrl_irq[6])
        else $error("unrouted interrupt reached controller");
    irq_illegal_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        (irq_route_q[0].routed && irq_route_q[0].number == 5'd8 && board_interrupt_line_i[0]
         && !isa_irq[8] && !other_hit[8]) |=> !ctrl_irq[8])
        else $error("interrupt routed to illegal input");
    line_idle_a : assert property (@(posedge ref_clk) disable iff (!rstn)
        !irq_route_q[0].timer_oe |=> !board_interrupt_line_oe[0])
        else $error("line driven outside timer mode");

endmodule // board_steer

// file: test/board_dev_model.sv
// Motherboard DMA devices and interrupt sources on the far side of the steering block
`timescale 1ns/1ps
module board_dev_model (
    input  wire logic       ref_clk,
    input  wire logic [1:0] req_want,
    input  wire logic [1:0] irq_want,
    input  wire logic [1:0] line_o,
    input  wire logic [1:0] line_oe,
    output logic      [1:0] board_dma_request,
    output logic      [1:0] line_i
);
    // Each device holds its request level until the bench changes it
    always_ff @(posedge ref_clk) begin
        board_dma_request <= req_want;
    end
    // Interrupts are active-high levels; the block wins the wire while it drives it
    assign line_i = (line_oe & line_o) | (~line_oe & irq_want);
endmodule // board_dev_model

// file: test/tb_top.sv
// Random and sweep test of DMA and interrupt steering through the register bus
`timescale 1ns/1ps
module tb_top;
    import steer_pkg::*;
    logic        ref_clk, rstn, hsel, hwrite, hreadyout, hresp, timer_irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, req_want, irq_want, req, ack_n, line_i, line_o, line_oe;
    logic [2:0]  hsize;
    logic [7:0]  isa_dack, isa_dreq;
    logic [15:0] isa_irq, ctrl_irq;
    logic [3:0]  dr[2];
    logic [7:0]  ir[2];
    integer      seed, n_mismatch, checks_done;

    board_steer dut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .board_dma_request(req), .board_dma_acknowledge_n(ack_n),
        .isa_dack(isa_dack), .isa_dreq(isa_dreq), .board_interrupt_line_i(line_i),
        .board_interrupt_line_o(line_o), .board_interrupt_line_oe(line_oe), .timer_irq(timer_irq),
        .isa_irq(isa_irq), .ctrl_irq(ctrl_irq));
    board_dev_model partner (.ref_clk(ref_clk), .req_want(req_want), .irq_want(irq_want), .line_o(line_o),
        .line_oe(line_oe), .board_dma_request(req), .line_i(line_i));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic stop_test;
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rdv);
        @(posedge ref_clk);
        hsel <= 1'b1; haddr <= {20'h00000, a}; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
        cmp(32'(hresp), 32'h0);
    endtask

    task automatic check_reset_regs;
        for (int k = 0; k < 4; k++) begin
            bus(12'(k * 4), 1'b0, 32'h0, rd);
            cmp(rd, k < 2 ? 32'(DMA_ROUTE_RESET) : 32'(IRQ_ROUTE_RESET));
        end
    endtask

    task automatic check_out;
        logic [7:0]  dq;
        logic [1:0]  ak, ok;
        logic [15:0] iq;
        dq = 8'h00; ak = 2'h3; iq = isa_irq;
        for (int p = 0; p < 2; p++) if (dr[p][3] && dr[p][2:0] != 3'h4) begin
            dq[dr[p][2:0]] |= req_want[p];
            if (isa_dack[dr[p][2:0]]) ak[p] = 1'b0;
        end
        for (int l = 0; l < 2; l++) begin
            ok[l] = ir[l][7] && !(l == 0 && ir[0][6]) && !ir[l][4] && IRQ_LEGAL[ir[l][3:0]];
            if (ok[l] && !ir[l][5]) iq[ir[l][3:0]] = 1'b0;
        end
        for (int l = 0; l < 2; l++) if (ok[l]) iq[ir[l][3:0]] |= irq_want[l];
        cmp(32'(isa_dreq), 32'(dq));
        cmp(32'(ack_n), 32'(ak));
        cmp(32'(ctrl_irq & IRQ_LEGAL), 32'(iq & IRQ_LEGAL));
        cmp(32'(line_oe), {31'h0, ir[0][6]});
        cmp(32'(line_o[0] & ir[0][6]), 32'(timer_irq & ir[0][6]));
        bus(STATUS_ADDR, 1'b0, 32'h0, rd);
        cmp(rd & {IRQ_LEGAL, 16'hFF00}, {iq & IRQ_LEGAL, dq, 8'h00});
    endtask

    initial begin
        #(25 * 30000);
        n_mismatch++;
        stop_test;
    end

    initial begin
        seed = 88; n_mismatch = 0; checks_done = 0;
        rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
        req_want = 2'h0; irq_want = 2'h0; isa_dack = 8'h00; isa_irq = 16'h0000; timer_irq = 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        check_reset_regs;
        bus(12'h014, 1'b1, 32'hFFFFFFFF, rd);
        bus(12'h014, 1'b0, 32'h0, rd);
        cmp(rd, 32'h0);
        for (int i = 0; i < 48; i++) begin
            dr[0] = {i < 40, 3'(i)};
            dr[1] = 4'($random(seed));
            ir[0] = {~i[5], i % 8 == 7, 1'($random(seed)), 1'b0, 4'(i)};
            ir[1] = 8'($random(seed)) & 8'hAF;
            bus(DMA_ROUTE0_ADDR, 1'b1, {28'h0, dr[0]}, rd);
            bus(DMA_ROUTE1_ADDR, 1'b1, {28'h0, dr[1]}, rd);
            bus(IRQ_ROUTE0_ADDR, 1'b1, {24'h0, ir[0]}, rd);
            bus(IRQ_ROUTE1_ADDR, 1'b1, {24'h0, ir[1]}, rd);
            bus(DMA_ROUTE1_ADDR, 1'b0, 32'h0, rd);
            cmp(rd, {28'h0, dr[1]});
            bus(IRQ_ROUTE1_ADDR, 1'b0, 32'h0, rd);
            cmp(rd, {24'h0, ir[1]});
            repeat (3) begin
                @(posedge ref_clk);
                req_want <= 2'($random(seed)); irq_want <= 2'($random(seed)); isa_dack <= 8'($random(seed));
                isa_irq <= 16'($random(seed)); timer_irq <= 1'($random(seed));
                repeat (3) @(posedge ref_clk);
                #1 check_out;
            end
        end
        @(posedge ref_clk);
        rstn <= 1'b0;
        @(posedge ref_clk);
        #1 cmp({ctrl_irq, isa_dreq, 6'h00, ack_n}, 32'h0000_0003);
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        check_reset_regs;
        stop_test;
    end
endmodule // tb_top
